//--- hdl/mdr_top.v
// Memory decode block: indirect table port, limit compare, page relocation and shadowing.
//
// Notes on behaviour
// - Index 29H then data write sets location.
// - Index 2AH then data write loads transfer value.
// - Control byte bit7 and bit6 set writes table.
// - Control byte bit7 set, bit6 clear reads table.
// - Data read at index 2AH returns fetched value.
// - Claim memory cycles below remap top, except relocation-window pages whose entry names no page; 640K-1M pages by descriptor alone.
// - Relocate only when remap top exceeds physical top.
// - Limits are 14 bits compared with address 27:14.
// - All page matching uses 16K granularity.
// - Page n lives at table location n plus 8.
// - Relocation entry: virtual page index, physical page+8.
// - Any 640K-1M page may move above top.
// - Relocation entries load in any order, any count.
// - Relocation, shadowing and translation coexist per page.
// - Each of 24 pages has own descriptor.
// - Shadow clear makes read/write enables irrelevant.
// - Shadowed page: read enable selects DRAM reads.
// - Shadowed page: write enable selects DRAM writes.
// - Six-bit descriptor layout, all bits reset zero.
// - DRAM if translate, else shadow with direction enable.
// - Port 28H sets index, port 24H accesses it.
// - Both limits reset to 040H.
`include "mdr_regs.vh"
module mdr_top (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire port_write_strobe_in,
  input wire port_read_strobe_in,
  input wire [7:0] io_addr_in,
  input wire [7:0] io_data_in,
  output reg [7:0] io_data_out,
  output reg io_data_oe_out,
  input wire mem_cycle_in,
  input wire mem_write_in,
  input wire [13:0] host_address_bus_in,
  output reg mem_claim_out,
  output reg mem_dram_out,
  output reg mem_relocated_out,
  output reg mem_cache_out,
  output reg [13:0] mem_addr_out,
  output reg remap_active_out
);

  localparam PAGES = `MDR_PAGE_COUNT;
  localparam SYNC_W = 34;

  // Reset release through two flip-flops; assertion stays asynchronous.
  reg rst_meta;
  reg rst_n;

  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // All host pins arrive from outside the clock domain.
  wire [SYNC_W-1:0] sync_bus;
  wire s_wr;
  wire s_rd;
  wire [7:0] s_io_addr;
  wire [7:0] s_io_data;
  wire s_cycle;
  wire s_write;
  wire [13:0] s_haddr;

  mdr_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n),
    .async_in({port_write_strobe_in, port_read_strobe_in, io_addr_in, io_data_in,
      mem_cycle_in, mem_write_in, host_address_bus_in}),
    .sync_out(sync_bus)
  );

  assign {s_wr, s_rd, s_io_addr, s_io_data, s_cycle, s_write, s_haddr} = sync_bus;

  // Configuration state.
  reg [7:0] index_reg;
  reg [7:0] table_loc;
  reg [7:0] xfer_data;
  reg [13:0] remap_top_limit;
  reg [13:0] physical_top_limit;
  reg [7:0] reloc_mem [0:PAGES-1];
  reg [5:0] desc_mem [0:PAGES-1];
  reg wr_prev;
  integer i;

  // A table location that names one of the 24 page descriptors.
  function loc_is_page;
    input [7:0] loc;
    begin
      loc_is_page = (loc >= `MDR_PAGE_LOC_BASE) && (loc < `MDR_PAGE_LOC_END);
    end
  endfunction

  // Page number held by a location that names a page.
  function [4:0] loc_to_page;
    input [7:0] loc;
    reg [7:0] diff;
    begin
      diff = loc - `MDR_PAGE_LOC_BASE;
      loc_to_page = diff[4:0];
    end
  endfunction

  // A relocation table slot is a virtual page number below 24.
  function loc_is_slot;
    input [7:0] loc;
    begin
      loc_is_slot = loc < `MDR_RELOC_SLOTS;
    end
  endfunction

  // Port write acts once, on the rising edge of the synchronised strobe.
  wire wr_rise;
  wire data_port_wr;
  wire index_port_wr;
  wire [3:0] ctl_sel;
  wire ctl_start;
  wire ctl_write;

  assign wr_rise = s_wr & ~wr_prev;
  assign index_port_wr = wr_rise && (s_io_addr == `MDR_IO_INDEX_PORT);
  assign data_port_wr = wr_rise && (s_io_addr == `MDR_IO_DATA_PORT);
  assign ctl_sel = s_io_data[`MDR_CTL_SEL_MSB:0];
  assign ctl_start = s_io_data[`MDR_CTL_START_BIT];
  assign ctl_write = s_io_data[`MDR_CTL_WRITE_BIT];

  // Value a read transfer fetches from the table named in the control byte.
  reg [7:0] fetch_val;

  always @*
  begin
    fetch_val = 8'h00;
    case (ctl_sel)
      `MDR_TBL_RELOC:
      begin
        if (loc_is_slot(table_loc))
          fetch_val = reloc_mem[table_loc[4:0]];
      end
      `MDR_TBL_DESC:
      begin
        if (loc_is_page(table_loc))
          fetch_val = {2'b00, desc_mem[loc_to_page(table_loc)]};
      end
      `MDR_TBL_REMAP_LO: fetch_val = remap_top_limit[`MDR_LIMIT_LO_MSB:0];
      `MDR_TBL_REMAP_HI: fetch_val = {2'b00, remap_top_limit[`MDR_LIMIT_HI_MSB:8]};
      `MDR_TBL_PHYS_LO: fetch_val = physical_top_limit[`MDR_LIMIT_LO_MSB:0];
      `MDR_TBL_PHYS_HI: fetch_val = {2'b00, physical_top_limit[`MDR_LIMIT_HI_MSB:8]};
      default: fetch_val = 8'h00;
    endcase
  end

  // Index, location, transfer data and the tables themselves. A transfer
  // finishes in the cycle its control byte is taken, which is long before
  // the synchronisers can deliver the next strobe edge.
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_prev <= 1'b0;
      index_reg <= `MDR_INDEX_RESET;
      table_loc <= `MDR_INDEX_RESET;
      xfer_data <= `MDR_INDEX_RESET;
      remap_top_limit <= `MDR_LIMIT_RESET;
      physical_top_limit <= `MDR_LIMIT_RESET;
      for (i = 0; i < PAGES; i = i + 1)
      begin
        reloc_mem[i] <= `MDR_RELOC_RESET;
        desc_mem[i] <= `MDR_DESC_RESET;
      end
    end
    else
    begin
      wr_prev <= s_wr;
      if (index_port_wr)
        index_reg <= s_io_data;
      if (data_port_wr)
      begin
        case (index_reg)
          `MDR_IDX_TABLE_LOC: table_loc <= s_io_data;
          `MDR_IDX_XFER_DATA: xfer_data <= s_io_data;
          `MDR_IDX_XFER_CTRL:
          begin
            if (ctl_start && !ctl_write)
              xfer_data <= fetch_val;
            else if (ctl_start)
            begin
              // Write transfer into the selected table or register.
              case (ctl_sel)
                `MDR_TBL_RELOC:
                begin
                  if (loc_is_slot(table_loc))
                    reloc_mem[table_loc[4:0]] <= xfer_data;
                end
                `MDR_TBL_DESC:
                begin
                  if (loc_is_page(table_loc))
                    desc_mem[loc_to_page(table_loc)] <=
                      xfer_data[5:0] & `MDR_DESC_WR_MASK;
                end
                // Limit halves do not use the location register.
                `MDR_TBL_REMAP_LO:
                  remap_top_limit[`MDR_LIMIT_LO_MSB:0] <= xfer_data;
                `MDR_TBL_REMAP_HI:
                  remap_top_limit[`MDR_LIMIT_HI_MSB:8] <= xfer_data[5:0];
                `MDR_TBL_PHYS_LO:
                  physical_top_limit[`MDR_LIMIT_LO_MSB:0] <= xfer_data;
                `MDR_TBL_PHYS_HI:
                  physical_top_limit[`MDR_LIMIT_HI_MSB:8] <= xfer_data[5:0];
                default:
                begin
                end
              endcase
            end
          end
          default:
          begin
          end
        endcase
      end
    end
  end

  // Data port read answer; other indices read as zero.
  reg [7:0] next_io_data;
  reg next_io_oe;

  always @*
  begin
    next_io_oe = s_rd && (s_io_addr == `MDR_IO_DATA_PORT);
    next_io_data = 8'h00;
    case (index_reg)
      `MDR_IDX_TABLE_LOC: next_io_data = table_loc;
      `MDR_IDX_XFER_DATA: next_io_data = xfer_data;
      default: next_io_data = 8'h00;
    endcase
    if (!next_io_oe)
      next_io_data = 8'h00;
  end

  // Limit comparison and page extraction for the current memory cycle.
  wire below_remap;
  wire remap_active;
  wire in_reloc;
  wire [4:0] reloc_vpage;
  wire in_low;
  wire [4:0] low_page;

  mdr_page_decode u_decode (
    .addr_in(s_haddr),
    .remap_top_limit_in(remap_top_limit),
    .physical_top_limit_in(physical_top_limit),
    .below_remap_out(below_remap),
    .remap_active_out(remap_active),
    .in_reloc_out(in_reloc),
    .reloc_vpage_out(reloc_vpage),
    .in_low_out(in_low),
    .low_page_out(low_page)
  );

  // Memory cycle decision. Relocation is checked first since it only covers
  // addresses at or above the physical top; the descriptors govern the
  // 640K-1M window directly, so each page can take a different role.
  reg next_claim;
  reg next_dram;
  reg next_reloc;
  reg next_cache;
  reg [13:0] next_addr;
  reg [7:0] reloc_entry;
  reg [5:0] page_desc;
  reg [4:0] phys_page;

  always @*
  begin
    next_claim = 1'b0;
    next_dram = 1'b0;
    next_reloc = 1'b0;
    next_cache = 1'b0;
    next_addr = s_haddr;
    reloc_entry = 8'h00;
    page_desc = 6'h00;
    phys_page = 5'h00;
    if (s_cycle)
    begin
      if (in_reloc)
      begin
        reloc_entry = reloc_mem[reloc_vpage];
        // An entry that names no page leaves the virtual page unanswered.
        if (loc_is_page(reloc_entry))
        begin
          phys_page = loc_to_page(reloc_entry);
          page_desc = desc_mem[phys_page];
          next_claim = 1'b1;
          next_dram = 1'b1;
          next_reloc = 1'b1;
          next_cache = page_desc[`MDR_DESC_CACHE];
          next_addr = `MDR_LOW_PAGE_ADDR + {9'h000, phys_page};
        end
      end
      else if (in_low)
      begin
        page_desc = desc_mem[low_page];
        // Without shadow enable the direction enables count for nothing.
        next_dram = page_desc[`MDR_DESC_TRANSLATE] |
          (page_desc[`MDR_DESC_SHADOW] &
          (s_write ? page_desc[`MDR_DESC_WRITE] :
          page_desc[`MDR_DESC_READ]));
        next_claim = next_dram;
        next_cache = next_dram & page_desc[`MDR_DESC_CACHE];
      end
      else if (below_remap)
      begin
        next_claim = 1'b1;
        next_dram = 1'b1;
        next_cache = 1'b1;
      end
    end
  end

  // Every output is a flip-flop; decisions trail the pins by three edges.
  always @(posedge clk_sys_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_data_out <= 8'h00;
      io_data_oe_out <= 1'b0;
      mem_claim_out <= 1'b0;
      mem_dram_out <= 1'b0;
      mem_relocated_out <= 1'b0;
      mem_cache_out <= 1'b0;
      mem_addr_out <= 14'h0000;
      remap_active_out <= 1'b0;
    end
    else
    begin
      io_data_out <= next_io_data;
      io_data_oe_out <= next_io_oe;
      mem_claim_out <= next_claim;
      mem_dram_out <= next_dram;
      mem_relocated_out <= next_reloc;
      mem_cache_out <= next_cache;
      mem_addr_out <= next_addr;
      remap_active_out <= remap_active;
    end
  end

endmodule

//--- hdl/mdr_regs.vh
// Port addresses, indices, table codes, field positions and reset values of the decode block.
`ifndef MDR_REGS_VH
`define MDR_REGS_VH
// Host I/O addresses of the index port and the data port.
`define MDR_IO_INDEX_PORT 8'h28
`define MDR_IO_DATA_PORT 8'h24
// Indices reached through the data port.
`define MDR_IDX_XFER_CTRL 8'h28
`define MDR_IDX_TABLE_LOC 8'h29
`define MDR_IDX_XFER_DATA 8'h2A
`define MDR_INDEX_RESET 8'h00
// Transfer control byte layout.
`define MDR_CTL_START_BIT 7
`define MDR_CTL_WRITE_BIT 6
`define MDR_CTL_SEL_MSB 3
// Table codes carried in the control byte.
`define MDR_TBL_RELOC 4'h0
`define MDR_TBL_DESC 4'h1
`define MDR_TBL_REMAP_LO 4'h2
`define MDR_TBL_REMAP_HI 4'h3
`define MDR_TBL_PHYS_LO 4'h4
`define MDR_TBL_PHYS_HI 4'h5
// Limit registers hold address bits 27:14; 040H is the 1MB boundary.
`define MDR_LIMIT_RESET 14'h0040
`define MDR_LIMIT_HI_MSB 13
`define MDR_LIMIT_LO_MSB 7
// Pages between 640K and 1M: 24 of them, page 0 at table location 8.
`define MDR_PAGE_COUNT 24
`define MDR_PAGE_SPAN 14'h0018
`define MDR_RELOC_SLOTS 8'h18
`define MDR_PAGE_LOC_BASE 8'h08
`define MDR_PAGE_LOC_END 8'h20
`define MDR_LOW_PAGE_ADDR 14'h0028
// Page descriptor fields.
`define MDR_DESC_SHADOW 0
`define MDR_DESC_READ 1
`define MDR_DESC_WRITE 2
`define MDR_DESC_CACHE 3
`define MDR_DESC_TRANSLATE 5
`define MDR_DESC_WR_MASK 6'h2F
`define MDR_DESC_RESET 6'h00
`define MDR_RELOC_RESET 8'h00
`endif

//--- hdl/mdr_sync.v
// Two-flip-flop synchroniser for a bundle of asynchronous pins.
module mdr_sync #(
  parameter WIDTH = 8
) (
  input wire clk_sys_in,
  input wire rst_n_in,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stable;

  // The first stage feeds only the second stage, never any logic.
  always @(posedge clk_sys_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta <= {WIDTH{1'b0}};
      stable <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      stable <= meta;
    end
  end

  assign sync_out = stable;

endmodule

//--- hdl/mdr_page_decode.v
// Address comparison against the two limits and page index extraction.
`include "mdr_regs.vh"
module mdr_page_decode (
  input wire [13:0] addr_in,
  input wire [13:0] remap_top_limit_in,
  input wire [13:0] physical_top_limit_in,
  output wire below_remap_out,
  output wire remap_active_out,
  output wire in_reloc_out,
  output wire [4:0] reloc_vpage_out,
  output wire in_low_out,
  output wire [4:0] low_page_out
);

  wire [13:0] vdiff;
  wire [13:0] ldiff;
  wire [13:0] low_end;

  // Only bits 27:14 are compared, so every decision is on 16K pages.
  assign below_remap_out = addr_in < remap_top_limit_in;
  assign remap_active_out = remap_top_limit_in > physical_top_limit_in;

  // Virtual page number counted upward from the physical top.
  assign vdiff = addr_in - physical_top_limit_in;
  assign reloc_vpage_out = vdiff[4:0];
  assign in_reloc_out = remap_active_out && below_remap_out &&
    (addr_in >= physical_top_limit_in) && (vdiff < `MDR_PAGE_SPAN);

  // Page index within the 640K to 1M region.
  assign low_end = `MDR_LOW_PAGE_ADDR + `MDR_PAGE_SPAN;
  assign ldiff = addr_in - `MDR_LOW_PAGE_ADDR;
  assign low_page_out = ldiff[4:0];
  assign in_low_out = (addr_in >= `MDR_LOW_PAGE_ADDR) && (addr_in < low_end);

endmodule

//--- sim/mdr_top_monitor.sv
// Concurrent checks on the ports of the memory decode block.
module mdr_top_monitor (
  input wire clk_sys_in,
  input wire arst_n_in,
  input wire port_write_strobe_in,
  input wire port_read_strobe_in,
  input wire [7:0] io_addr_in,
  input wire [7:0] io_data_out,
  input wire io_data_oe_out,
  input wire mem_cycle_in,
  input wire [13:0] host_address_bus_in,
  input wire mem_claim_out,
  input wire mem_dram_out,
  input wire mem_relocated_out,
  input wire [13:0] mem_addr_out,
  input wire remap_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] up_cnt;
  logic [3:0] wr_age;
  // Pin-to-output checks wait until the synchronisers have filled after reset.
  always @(posedge clk_sys_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      up_cnt <= 4'h0;
      wr_age <= 4'hF;
    end
    else
    begin
      up_cnt <= (up_cnt == 4'hF) ? up_cnt : up_cnt + 4'h1;
      wr_age <= port_write_strobe_in ? 4'h0 : ((wr_age == 4'hF) ? wr_age : wr_age + 4'h1);
    end
  end
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!arst_n_in);
  sequence read_start;
    up_cnt > 4'h8 && $rose(port_read_strobe_in) && io_addr_in == 8'h24;
  endsequence
  sequence data_driven;
    ##[1:4] io_data_oe_out;
  endsequence
  read_answer_a: assert property (read_start |-> data_driven)
    else $error("data port read not answered");
  oe_source_a: assert property (io_data_oe_out |-> $past(port_read_strobe_in, 2)
    || $past(port_read_strobe_in, 3) || $past(port_read_strobe_in, 4))
    else $error("data bus driven without a read");
  oe_zero_a: assert property (!io_data_oe_out |-> io_data_out == 8'h00)
    else $error("read data not zero while undriven");
  idle_cycle_a: assert property (up_cnt > 4'h8 && !$past(mem_cycle_in, 3)
    |-> !mem_claim_out && !mem_dram_out && !mem_relocated_out)
    else $error("idle bus claimed");
  addr_pass_a: assert property (up_cnt > 4'h8 && !mem_relocated_out
    |-> mem_addr_out == $past(host_address_bus_in, 3))
    else $error("address altered without relocation");
  reloc_claim_a: assert property (mem_relocated_out |-> mem_claim_out && mem_dram_out)
    else $error("relocated cycle not claimed");
  reloc_range_a: assert property (mem_relocated_out
    |-> mem_addr_out >= 14'h0028 && mem_addr_out <= 14'h003F)
    else $error("relocated address outside low pages");
  claim_dram_a: assert property (mem_claim_out |-> mem_dram_out)
    else $error("claimed cycle not sent to dram");
  remap_cause_a: assert property ($changed(remap_active_out) |-> wr_age < 4'h9)
    else $error("remap flag moved without a port write");
endmodule

//--- sim/mdr_host_model.sv
// Host processor model: port I/O cycles and memory cycles toward the decode block.
module mdr_host_model (
  input wire logic clk_sys_in,
  input wire logic [7:0] io_data_in,
  output logic port_write_strobe_out = 1'b0,
  output logic port_read_strobe_out = 1'b0,
  output logic [7:0] io_addr_out = 8'h00,
  output logic [7:0] io_data_out = 8'h00,
  output logic mem_cycle_out = 1'b0,
  output logic mem_write_out = 1'b0,
  output logic [13:0] host_address_bus_out = 14'h0000
);
  timeunit 1ns;
  timeprecision 1ps;
  // Address and data settle three edges before the strobe, which stays high four edges.
  task automatic port_cycle(input logic rd, input logic [7:0] a, input logic [7:0] d,
                            output logic [7:0] q);
    io_addr_out <= a;
    io_data_out <= d;
    repeat (3) @(posedge clk_sys_in);
    port_read_strobe_out <= rd;
    port_write_strobe_out <= !rd;
    repeat (4) @(posedge clk_sys_in);
    q = io_data_in;
    port_read_strobe_out <= 1'b0;
    port_write_strobe_out <= 1'b0;
    // A released bus must not keep showing the old value.
    io_data_out <= ~d;
    repeat (3) @(posedge clk_sys_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    port_cycle(1'b0, a, d, q);
  endtask
  // Codes 2 to 5 are single limit registers, so the location step is skipped for them.
  task automatic tbl_write(input logic [3:0] t, input logic [7:0] loc, input logic [7:0] v);
    if (t < 4'h2)
    begin
      wr(8'h28, 8'h29);
      wr(8'h24, loc);
    end
    wr(8'h28, 8'h2A);
    wr(8'h24, v);
    wr(8'h28, 8'h28);
    wr(8'h24, {4'hC, t});
  endtask
  task automatic tbl_read(input logic [3:0] t, input logic [7:0] loc, output logic [7:0] q);
    if (t < 4'h2)
    begin
      wr(8'h28, 8'h29);
      wr(8'h24, loc);
    end
    wr(8'h28, 8'h28);
    wr(8'h24, {4'h8, t});
    wr(8'h28, 8'h2A);
    port_cycle(1'b1, 8'h24, 8'h00, q);
  endtask
  // Memory cycle held long enough for the three-edge pipeline.
  task automatic mem(input logic c, input logic w, input logic [13:0] a);
    mem_cycle_out <= c;
    mem_write_out <= w;
    host_address_bus_out <= a;
    repeat (5) @(posedge clk_sys_in);
  endtask
endmodule

//--- sim/memory_decode_remap_shadow_tb.sv
// Testbench of the memory decode block: table port, limits, relocation and shadowing.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module memory_decode_remap_shadow_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_in = 1'b0;
  logic arst_n_in = 1'b0;
  wire wr_stb, rd_stb, io_oe, mem_cyc, mem_wr, claim, dram, reloc, cache, remap_on;
  wire [7:0] io_addr, io_wdata, io_rdata;
  wire [13:0] host_addr, dram_addr;
  int n_mismatch = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] q;
  mdr_top DUT (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .port_write_strobe_in(wr_stb),
    .port_read_strobe_in(rd_stb), .io_addr_in(io_addr), .io_data_in(io_wdata),
    .io_data_out(io_rdata), .io_data_oe_out(io_oe), .mem_cycle_in(mem_cyc),
    .mem_write_in(mem_wr), .host_address_bus_in(host_addr), .mem_claim_out(claim),
    .mem_dram_out(dram), .mem_relocated_out(reloc), .mem_cache_out(cache),
    .mem_addr_out(dram_addr), .remap_active_out(remap_on));
  mdr_host_model host (.clk_sys_in(clk_sys_in), .io_data_in(io_rdata),
    .port_write_strobe_out(wr_stb), .port_read_strobe_out(rd_stb), .io_addr_out(io_addr),
    .io_data_out(io_wdata), .mem_cycle_out(mem_cyc), .mem_write_out(mem_wr),
    .host_address_bus_out(host_addr));
  // The 40 MHz clock.
  initial
  begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // A hang is cut short well beyond the roughly 1500 cycles the run needs.
  always @(posedge clk_sys_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic mem_check(input logic [13:0] a, input logic cl, input logic rl,
                           input logic [13:0] ea);
    host.mem(1'b1, 1'b0, a);
    `CHK(claim, cl)
    `CHK(reloc, rl)
    `CHK(dram_addr, ea)
  endtask
  // Both limits come out of reset at the 1MB boundary.
  task automatic reset_values();
    logic [7:0] ex [4] = '{8'h40, 8'h00, 8'h40, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      host.tbl_read(4'(i + 2), 8'hFF, q);
      `CHK(q, ex[i])
    end
    `CHK(remap_on, 1'b0)
  endtask
  // Every descriptor mode on a page of its own, read and write cycles both.
  task automatic shadow_modes();
    logic [5:0] dv [6] = '{6'h3F, 6'h01, 6'h03, 6'h05, 6'h06, 6'h20};
    logic [1:0] ex [6] = '{2'b11, 2'b00, 2'b10, 2'b01, 2'b00, 2'b11};
    logic [7:0] loc;
    for (int i = 0; i < 6; i++)
    begin
      loc = 8'h1F - 8'(i * 4);
      host.tbl_write(4'h1, loc, {2'b00, dv[i]});
      host.tbl_read(4'h1, loc, q);
      `CHK(q, {2'b00, dv[i] & 6'h2F})
      host.mem(1'b1, 1'b0, loc + 14'h0020);
      `CHK(dram, ex[i][1])
      `CHK(claim, ex[i][1])
      `CHK(cache, dv[i][3])
      host.mem(1'b1, 1'b1, loc + 14'h0020);
      `CHK(dram, ex[i][0])
    end
    host.mem(1'b0, 1'b0, 14'h003F);
    `CHK(claim, 1'b0)
  endtask
  // Eight pages above physical top, loaded out of order, then both limits raised.
  task automatic remap_pages();
    host.tbl_write(4'h2, 8'hFF, 8'h48);
    host.tbl_write(4'h0, 8'h07, 8'h1F);
    host.tbl_write(4'h0, 8'h00, 8'h0D);
    host.tbl_read(4'h0, 8'h07, q);
    `CHK(q, 8'h1F)
    `CHK(remap_on, 1'b1)
    mem_check(14'h0040, 1'b1, 1'b1, 14'h002D);
    mem_check(14'h0047, 1'b1, 1'b1, 14'h003F);
    mem_check(14'h0041, 1'b0, 1'b0, 14'h0041);
    mem_check(14'h0048, 1'b0, 1'b0, 14'h0048);
    mem_check(14'h0010, 1'b1, 1'b0, 14'h0010);
    host.tbl_write(4'h3, 8'h00, 8'h01);
    host.tbl_write(4'h5, 8'h00, 8'h01);
    mem_check(14'h0140, 1'b1, 1'b1, 14'h002D);
    mem_check(14'h0148, 1'b0, 1'b0, 14'h0148);
    // Lowering the physical top by its low half moves the window down, still within 24 pages.
    host.tbl_write(4'h4, 8'h00, 8'h38);
    mem_check(14'h013F, 1'b1, 1'b1, 14'h003F);
    host.tbl_write(4'h4, 8'h00, 8'h40);
    host.tbl_write(4'h2, 8'h00, 8'h40);
    `CHK(remap_on, 1'b0)
    mem_check(14'h0140, 1'b0, 1'b0, 14'h0140);
  endtask
  // An unused index reads zero, and a control byte without its start bit does nothing.
  task automatic refused_index();
    host.wr(8'h28, 8'h2B);
    host.wr(8'h24, 8'h55);
    host.port_cycle(1'b1, 8'h24, 8'h00, q);
    `CHK(q, 8'h00)
    host.wr(8'h28, 8'h2A);
    host.wr(8'h24, 8'h50);
    host.wr(8'h28, 8'h28);
    host.wr(8'h24, 8'h42);
    `CHK(remap_on, 1'b0)
    // The location register reads back, and a relocation slot past 23 reads zero.
    host.wr(8'h28, 8'h29);
    host.wr(8'h24, 8'h13);
    host.port_cycle(1'b1, 8'h24, 8'h00, q);
    `CHK(q, 8'h13)
    host.tbl_read(4'h0, 8'h1F, q);
    `CHK(q, 8'h00)
  endtask
  // Reset for six cycles, then the scenarios in turn.
  initial
  begin
    repeat (6) @(posedge clk_sys_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    reset_values();
    shadow_modes();
    remap_pages();
    refused_index();
    end_of_test();
  end
endmodule
bind mdr_top mdr_top_monitor MON (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
  .port_write_strobe_in(port_write_strobe_in), .port_read_strobe_in(port_read_strobe_in),
  .io_addr_in(io_addr_in), .io_data_out(io_data_out), .io_data_oe_out(io_data_oe_out),
  .mem_cycle_in(mem_cycle_in), .host_address_bus_in(host_address_bus_in),
  .mem_claim_out(mem_claim_out), .mem_dram_out(mem_dram_out),
  .mem_relocated_out(mem_relocated_out), .mem_addr_out(mem_addr_out),
  .remap_active_out(remap_active_out));
